/* include/cbe_link_consts.svh */
// constants shared by both ends of the command/byte-enable link
`ifndef CBE_LINK_CONSTS_SVH
`define CBE_LINK_CONSTS_SVH
`define CBE_W 4
`define AD_W 32
`define CLK_PERIOD_NS 8
`define LINK_PERIOD_NS 32
`define LINK_HALF_CYC (`LINK_PERIOD_NS / 2 / `CLK_PERIOD_NS)
`define LINK_RST_CYC 4'h8
`define CMD_MEM_WRITE 4'h7
`define BE_NONE 4'hF
`define AD_IDLE 32'h00000000
`define WORD_STEP 32'h00000004
`define SEL_HI 31
`define SEL_LO 16
`define DEV_BASE 16'hA000
`endif

/* include/cbe_link_pkg.sv */
// types shared by both ends of the command/byte-enable link
`default_nettype none
`include "cbe_link_consts.svh"
package cbe_link_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h3,
    ST_TURN = 2'h2
  } link_state_type;
  typedef logic [`CBE_W-1:0] cbe_type;
  typedef logic [`AD_W-1:0] word_type;
endpackage
`default_nettype wire

/* include/cbe_link_if.sv */
// link wires between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
`include "cbe_link_consts.svh"
interface cbe_link_if;
  logic host_bus_clock;
  logic bus_reset_n;
  logic dev_req;
  logic dev_gnt;
  cbe_link_pkg::cbe_type h_cbe;
  cbe_link_pkg::cbe_type d_cbe;
  logic h_cbe_oe;
  logic d_cbe_oe;
  cbe_link_pkg::word_type h_ad;
  cbe_link_pkg::word_type d_ad;
  logic h_ad_oe;
  logic d_ad_oe;
  logic h_frame_n;
  logic d_frame_n;
  logic h_frame_oe;
  logic d_frame_oe;
  cbe_link_pkg::cbe_type cmd_byte_enable_bus;
  cbe_link_pkg::word_type ad_bus;
  logic frame_n;
  // undriven cbe and frame wires float to their pulled-up level; undriven ad reads zero
  assign cmd_byte_enable_bus = d_cbe_oe ? d_cbe :
                               (h_cbe_oe ? h_cbe : `BE_NONE);
  assign ad_bus = d_ad_oe ? d_ad : (h_ad_oe ? h_ad : `AD_IDLE);
  assign frame_n = d_frame_oe ? d_frame_n :
                   (h_frame_oe ? h_frame_n : 1'b1);
  modport host (
    output host_bus_clock, bus_reset_n, dev_gnt,
    output h_cbe, h_cbe_oe, h_ad, h_ad_oe, h_frame_n, h_frame_oe,
    input dev_req, cmd_byte_enable_bus, ad_bus, frame_n
  );
  modport device (
    input host_bus_clock, bus_reset_n, dev_gnt,
    output dev_req,
    output d_cbe, d_cbe_oe, d_ad, d_ad_oe, d_frame_n, d_frame_oe,
    input cmd_byte_enable_bus, ad_bus, frame_n
  );
endinterface
`default_nettype wire

/* logic/sync2.sv */
// two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  input wire logic clk_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  always_ff @(posedge clk_i) begin
    meta_ff <= d_i;
    q_o <= meta_ff;
  end
endmodule
`default_nettype wire

/* logic/cbe_device_end.sv */
// device end: command/byte-enable pins, clocked by the host bus clock
`timescale 1ns/100ps
`default_nettype none
`include "cbe_link_consts.svh"
module cbe_device_end (
  input wire logic clk_i,
  input wire logic reset_n_i,
  cbe_link_if.device link,
  input wire logic init_start_i,
  input wire cbe_link_pkg::cbe_type init_cmd_i,
  input wire cbe_link_pkg::word_type init_addr_i,
  input wire cbe_link_pkg::word_type init_data_i,
  input wire cbe_link_pkg::cbe_type init_be_n_i,
  output logic init_busy_o,
  output logic init_done_o,
  output logic tgt_valid_o,
  output cbe_link_pkg::cbe_type tgt_cmd_o,
  output cbe_link_pkg::word_type tgt_addr_o,
  output cbe_link_pkg::word_type tgt_data_o,
  output cbe_link_pkg::cbe_type tgt_be_n_o,
  output logic host_bus_clock_buffered_out_o
);
  wire logic lk_clk;
  wire logic lk_rst_n;
  wire logic req_sync;
  wire logic done_sync;
  wire logic tgt_sync;

  // core-side request holding registers
  logic req_tgl_ff;
  logic done_seen_ff;
  logic tgt_seen_ff;
  cbe_link_pkg::cbe_type cmd_hold_ff;
  cbe_link_pkg::cbe_type be_hold_ff;
  cbe_link_pkg::word_type addr_hold_ff;
  cbe_link_pkg::word_type data_hold_ff;

  // link-side registers
  cbe_link_pkg::link_state_type lk_state_ff;
  logic lk_req_seen_ff;
  logic lk_done_tgl_ff;
  logic lk_busy_ff;
  logic lk_sel_ff;
  logic lk_tgt_tgl_ff;
  logic lk_dev_req_ff;
  cbe_link_pkg::cbe_type lk_tgt_cmd_ff;
  cbe_link_pkg::cbe_type lk_tgt_be_ff;
  cbe_link_pkg::word_type lk_next_addr_ff;
  cbe_link_pkg::word_type lk_tgt_addr_ff;
  cbe_link_pkg::word_type lk_tgt_data_ff;
  cbe_link_pkg::cbe_type cbe_ff;
  cbe_link_pkg::word_type ad_ff;
  logic frame_n_ff;
  logic cbe_oe_ff;
  logic ad_oe_ff;
  logic frame_oe_ff;

  assign lk_clk = link.host_bus_clock;
  // plain buffer, no flop, so the copy keeps the clock's own edges
  assign host_bus_clock_buffered_out_o = lk_clk;

  // pins reach the host only from flops on the bus clock
  assign link.dev_req = lk_dev_req_ff;
  assign link.d_cbe = cbe_ff;
  assign link.d_cbe_oe = cbe_oe_ff;
  assign link.d_ad = ad_ff;
  assign link.d_ad_oe = ad_oe_ff;
  assign link.d_frame_n = frame_n_ff;
  assign link.d_frame_oe = frame_oe_ff;

  sync2 u_rst_sync (
    .clk_i(lk_clk),
    .d_i(link.bus_reset_n),
    .q_o(lk_rst_n)
  );

  sync2 u_req_sync (
    .clk_i(lk_clk),
    .d_i(req_tgl_ff),
    .q_o(req_sync)
  );

  sync2 u_done_sync (
    .clk_i(clk_i),
    .d_i(lk_done_tgl_ff),
    .q_o(done_sync)
  );

  sync2 u_tgt_sync (
    .clk_i(clk_i),
    .d_i(lk_tgt_tgl_ff),
    .q_o(tgt_sync)
  );

  // ---------------- core clock side ----------------
  wire logic take_req;
  wire logic done_evt;
  wire logic tgt_evt;
  assign take_req = init_start_i && !init_busy_o;
  assign done_evt = done_sync != done_seen_ff;
  assign tgt_evt = tgt_sync != tgt_seen_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      req_tgl_ff <= 1'b0;
      done_seen_ff <= 1'b0;
      tgt_seen_ff <= 1'b0;
      init_busy_o <= 1'b0;
      init_done_o <= 1'b0;
      cmd_hold_ff <= `CMD_MEM_WRITE;
      be_hold_ff <= `BE_NONE;
      addr_hold_ff <= `AD_IDLE;
      data_hold_ff <= `AD_IDLE;
    end else begin
      done_seen_ff <= done_sync;
      tgt_seen_ff <= tgt_sync;
      init_done_o <= done_evt;
      if (take_req) begin
        req_tgl_ff <= ~req_tgl_ff;
        init_busy_o <= 1'b1;
        cmd_hold_ff <= init_cmd_i;
        be_hold_ff <= init_be_n_i;
        addr_hold_ff <= init_addr_i;
        data_hold_ff <= init_data_i;
      end else if (done_evt) begin
        init_busy_o <= 1'b0;
      end
    end
  end

  // link-side capture registers are stable once their toggle has crossed
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tgt_valid_o <= 1'b0;
      tgt_cmd_o <= `CMD_MEM_WRITE;
      tgt_addr_o <= `AD_IDLE;
      tgt_data_o <= `AD_IDLE;
      tgt_be_n_o <= `BE_NONE;
    end else begin
      tgt_valid_o <= tgt_evt;
      if (tgt_evt) begin
        tgt_cmd_o <= lk_tgt_cmd_ff;
        tgt_addr_o <= lk_tgt_addr_ff;
        tgt_data_o <= lk_tgt_data_ff;
        tgt_be_n_o <= lk_tgt_be_ff;
      end
    end
  end

  // ---------------- bus clock side ----------------
  wire logic pending;
  wire logic bus_idle;
  wire logic addr_phase;
  wire logic data_phase;
  wire logic own_txn;
  wire logic hit;
  assign pending = req_sync != lk_req_seen_ff;
  assign bus_idle = link.frame_n && !lk_busy_ff;
  assign addr_phase = !link.frame_n && !lk_busy_ff;
  assign data_phase = !link.frame_n && lk_busy_ff;
  assign own_txn = lk_state_ff != cbe_link_pkg::ST_IDLE;
  assign hit = (link.ad_bus[`SEL_HI:`SEL_LO] == `DEV_BASE) &&
               (link.cmd_byte_enable_bus == `CMD_MEM_WRITE);

  // initiator: address cycle, one data cycle, one cycle driving frame high
  always_ff @(posedge lk_clk) begin
    if (!lk_rst_n) begin
      lk_state_ff <= cbe_link_pkg::ST_IDLE;
      lk_req_seen_ff <= 1'b0;
      lk_done_tgl_ff <= 1'b0;
      lk_dev_req_ff <= 1'b0;
      cbe_ff <= `BE_NONE;
      ad_ff <= `AD_IDLE;
      frame_n_ff <= 1'b1;
      cbe_oe_ff <= 1'b0;
      ad_oe_ff <= 1'b0;
      frame_oe_ff <= 1'b0;
    end else begin
      unique case (lk_state_ff)
        cbe_link_pkg::ST_IDLE: begin
          lk_dev_req_ff <= pending;
          if (pending && lk_dev_req_ff && link.dev_gnt && bus_idle) begin
            lk_state_ff <= cbe_link_pkg::ST_ADDR;
            lk_req_seen_ff <= req_sync;
            lk_dev_req_ff <= 1'b0;
            cbe_ff <= cmd_hold_ff;
            ad_ff <= addr_hold_ff;
            frame_n_ff <= 1'b0;
            cbe_oe_ff <= 1'b1;
            ad_oe_ff <= 1'b1;
            frame_oe_ff <= 1'b1;
          end
        end
        cbe_link_pkg::ST_ADDR: begin
          lk_state_ff <= cbe_link_pkg::ST_DATA;
          cbe_ff <= be_hold_ff;
          ad_ff <= data_hold_ff;
        end
        cbe_link_pkg::ST_DATA: begin
          lk_state_ff <= cbe_link_pkg::ST_TURN;
          frame_n_ff <= 1'b1;
          cbe_oe_ff <= 1'b0;
          ad_oe_ff <= 1'b0;
          cbe_ff <= `BE_NONE;
        end
        cbe_link_pkg::ST_TURN: begin
          lk_state_ff <= cbe_link_pkg::ST_IDLE;
          frame_oe_ff <= 1'b0;
          lk_done_tgl_ff <= ~lk_done_tgl_ff;
        end
      endcase
    end
  end

  // target: never drives, samples every rise, one word per data cycle
  always_ff @(posedge lk_clk) begin
    if (!lk_rst_n) begin
      lk_busy_ff <= 1'b0;
      lk_sel_ff <= 1'b0;
      lk_tgt_tgl_ff <= 1'b0;
      lk_tgt_cmd_ff <= `CMD_MEM_WRITE;
      lk_tgt_be_ff <= `BE_NONE;
      lk_next_addr_ff <= `AD_IDLE;
      lk_tgt_addr_ff <= `AD_IDLE;
      lk_tgt_data_ff <= `AD_IDLE;
    end else begin
      lk_busy_ff <= !link.frame_n;
      if (addr_phase && !own_txn && hit) begin
        lk_sel_ff <= 1'b1;
        lk_tgt_cmd_ff <= link.cmd_byte_enable_bus;
        lk_next_addr_ff <= link.ad_bus;
      end else if (data_phase && lk_sel_ff) begin
        lk_tgt_be_ff <= link.cmd_byte_enable_bus;
        lk_tgt_data_ff <= link.ad_bus;
        lk_tgt_addr_ff <= lk_next_addr_ff;
        lk_next_addr_ff <= lk_next_addr_ff + `WORD_STEP;
        lk_tgt_tgl_ff <= ~lk_tgt_tgl_ff;
      end else if (link.frame_n) begin
        lk_sel_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/cbe_host_end.sv */
// host end: makes the bus clock, starts writes, grants and receives
`timescale 1ns/100ps
`default_nettype none
`include "cbe_link_consts.svh"
module cbe_host_end (
  input wire logic clk_i,
  input wire logic reset_n_i,
  cbe_link_if.host link,
  input wire logic start_i,
  input wire cbe_link_pkg::cbe_type cmd_i,
  input wire cbe_link_pkg::word_type addr_i,
  input wire cbe_link_pkg::word_type data_i,
  input wire cbe_link_pkg::cbe_type be_n_i,
  output logic busy_o,
  output logic done_o,
  output logic rx_valid_o,
  output cbe_link_pkg::cbe_type rx_cmd_o,
  output cbe_link_pkg::word_type rx_addr_o,
  output cbe_link_pkg::word_type rx_data_o,
  output cbe_link_pkg::cbe_type rx_be_n_o
);
  logic [3:0] div_ff;
  logic lclk_ff;
  logic [3:0] rst_cnt_ff;
  logic bus_rst_n_ff;
  cbe_link_pkg::link_state_type state_ff;
  logic gnt_ff;
  logic gnt_seen_ff;
  logic busy_ph_ff;
  logic rsel_ff;
  logic s_frame_n_ff;
  logic s_req_ff;
  cbe_link_pkg::cbe_type cmd_ff;
  cbe_link_pkg::cbe_type be_ff;
  cbe_link_pkg::word_type addr_ff;
  cbe_link_pkg::word_type data_ff;
  cbe_link_pkg::word_type rnext_ff;
  cbe_link_pkg::cbe_type cbe_ff;
  cbe_link_pkg::word_type ad_ff;
  logic frame_n_ff;
  logic cbe_oe_ff;
  logic ad_oe_ff;
  logic frame_oe_ff;

  wire logic tog;
  wire logic rise;
  wire logic fall;
  assign tog = div_ff == 4'(`LINK_HALF_CYC - 1);
  assign rise = tog && !lclk_ff;
  assign fall = tog && lclk_ff;

  assign link.host_bus_clock = lclk_ff;
  assign link.bus_reset_n = bus_rst_n_ff;
  assign link.dev_gnt = gnt_ff;
  assign link.h_cbe = cbe_ff;
  assign link.h_cbe_oe = cbe_oe_ff;
  assign link.h_ad = ad_ff;
  assign link.h_ad_oe = ad_oe_ff;
  assign link.h_frame_n = frame_n_ff;
  assign link.h_frame_oe = frame_oe_ff;

  // divider, bus reset, and pin samples taken just before each rise
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_ff <= 4'h0;
      lclk_ff <= 1'b0;
      rst_cnt_ff <= 4'h0;
      bus_rst_n_ff <= 1'b0;
      s_frame_n_ff <= 1'b1;
      s_req_ff <= 1'b0;
    end else begin
      div_ff <= tog ? 4'h0 : div_ff + 4'h1;
      if (tog) begin
        lclk_ff <= ~lclk_ff;
      end
      if (rise) begin
        s_frame_n_ff <= link.frame_n;
        s_req_ff <= link.dev_req;
        if (rst_cnt_ff != `LINK_RST_CYC) begin
          rst_cnt_ff <= rst_cnt_ff + 4'h1;
        end
        bus_rst_n_ff <= rst_cnt_ff == `LINK_RST_CYC;
      end
    end
  end

  // outputs change mid-period so the device sees them settled at rise
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= cbe_link_pkg::ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      gnt_ff <= 1'b0;
      gnt_seen_ff <= 1'b0;
      cmd_ff <= `CMD_MEM_WRITE;
      be_ff <= `BE_NONE;
      addr_ff <= `AD_IDLE;
      data_ff <= `AD_IDLE;
      cbe_ff <= `BE_NONE;
      ad_ff <= `AD_IDLE;
      frame_n_ff <= 1'b1;
      cbe_oe_ff <= 1'b0;
      ad_oe_ff <= 1'b0;
      frame_oe_ff <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cmd_ff <= cmd_i;
        be_ff <= be_n_i;
        addr_ff <= addr_i;
        data_ff <= data_i;
      end
      if (fall && bus_rst_n_ff) begin
        unique case (state_ff)
          cbe_link_pkg::ST_IDLE: begin
            frame_oe_ff <= 1'b0;
            if (busy_o && s_frame_n_ff) begin
              state_ff <= cbe_link_pkg::ST_ADDR;
              cbe_ff <= cmd_ff;
              ad_ff <= addr_ff;
              frame_n_ff <= 1'b0;
              cbe_oe_ff <= 1'b1;
              ad_oe_ff <= 1'b1;
              frame_oe_ff <= 1'b1;
            end else if (s_req_ff && s_frame_n_ff) begin
              state_ff <= cbe_link_pkg::ST_TURN;
              gnt_ff <= 1'b1;
              gnt_seen_ff <= 1'b0;
            end
          end
          cbe_link_pkg::ST_ADDR: begin
            state_ff <= cbe_link_pkg::ST_DATA;
            cbe_ff <= be_ff;
            ad_ff <= data_ff;
          end
          cbe_link_pkg::ST_DATA: begin
            state_ff <= cbe_link_pkg::ST_IDLE;
            frame_n_ff <= 1'b1;
            cbe_oe_ff <= 1'b0;
            ad_oe_ff <= 1'b0;
            cbe_ff <= `BE_NONE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
          cbe_link_pkg::ST_TURN: begin
            if (!s_frame_n_ff) begin
              gnt_ff <= 1'b0;
              gnt_seen_ff <= 1'b1;
            end else if (gnt_seen_ff) begin
              state_ff <= cbe_link_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // receive the device's writes whose address cycle comes while the host is in ST_TURN
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy_ph_ff <= 1'b0;
      rsel_ff <= 1'b0;
      rnext_ff <= `AD_IDLE;
      rx_valid_o <= 1'b0;
      rx_cmd_o <= `CMD_MEM_WRITE;
      rx_addr_o <= `AD_IDLE;
      rx_data_o <= `AD_IDLE;
      rx_be_n_o <= `BE_NONE;
    end else begin
      rx_valid_o <= 1'b0;
      if (rise) begin
        busy_ph_ff <= !link.frame_n;
        if (!link.frame_n && !busy_ph_ff &&
            state_ff == cbe_link_pkg::ST_TURN) begin
          rsel_ff <= 1'b1;
          rx_cmd_o <= link.cmd_byte_enable_bus;
          rnext_ff <= link.ad_bus;
        end else if (!link.frame_n && busy_ph_ff && rsel_ff) begin
          rx_valid_o <= 1'b1;
          rx_be_n_o <= link.cmd_byte_enable_bus;
          rx_data_o <= link.ad_bus;
          rx_addr_o <= rnext_ff;
          rnext_ff <= rnext_ff + `WORD_STEP;
        end else if (link.frame_n) begin
          rsel_ff <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/cbe_link_asserts.sv */
// assertions on the command/byte-enable link wires
`timescale 1ns/100ps
`default_nettype none
module cbe_link_asserts (
  input wire logic host_bus_clock,
  input wire logic bus_reset_n,
  input wire logic dev_req,
  input wire logic dev_gnt,
  input wire cbe_link_pkg::cbe_type d_cbe,
  input wire logic h_cbe_oe,
  input wire logic d_cbe_oe,
  input wire logic d_ad_oe,
  input wire logic h_frame_oe,
  input wire logic d_frame_oe,
  input wire logic frame_n
);
  logic oe_fall_ff;
  cbe_link_pkg::cbe_type cbe_fall_ff;
  // device pins mid-period; they must not move again before the rise
  always_ff @(negedge host_bus_clock) begin
    oe_fall_ff <= d_cbe_oe;
    cbe_fall_ff <= d_cbe;
  end
  a_no_contention:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      !(d_cbe_oe && h_cbe_oe)) else $error("both ends drive cbe");
  a_dev_granted:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      $rose(d_cbe_oe) |-> dev_gnt) else $error("device drove ungranted");
  a_dev_addr_data:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      $rose(d_cbe_oe) |-> (!frame_n && d_frame_oe) ##1
      (d_cbe_oe && !frame_n) ##1 (!d_cbe_oe && frame_n))
      else $error("device cycle order wrong");
  a_dev_rise_only:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      (d_cbe_oe || oe_fall_ff) |-> ({d_cbe_oe, d_cbe} ==
      {oe_fall_ff, cbe_fall_ff})) else $error("device cbe moved off rise");
  a_dev_own_frame:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      d_cbe_oe |-> d_frame_oe) else $error("cbe driven outside frame");
  a_host_addr_data:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      $rose(h_cbe_oe) |-> (!frame_n && h_frame_oe) ##1
      (h_cbe_oe && !frame_n) ##1 (!h_cbe_oe && frame_n))
      else $error("host cycle order wrong");
  a_grant_start:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      dev_req && dev_gnt |=> d_cbe_oe && !dev_req)
      else $error("device did not start on grant");
  a_ad_with_cbe:
    assert property (@(posedge host_bus_clock) disable iff (!bus_reset_n)
      d_cbe_oe == d_ad_oe) else $error("ad and cbe enables differ");
  c_dev_write: cover property (@(posedge host_bus_clock) $rose(d_cbe_oe));
  c_host_write: cover property (@(posedge host_bus_clock) $rose(h_cbe_oe));
  c_grant: cover property (@(posedge host_bus_clock) dev_req && dev_gnt);
endmodule
`default_nettype wire

/* testbench/pci_command_byte_enable_pins_tb_top.sv */
// self-checking bench for the host and device ends of the link
`timescale 1ns/100ps
`default_nettype none
module pci_command_byte_enable_pins_tb_top;
  typedef struct {
    cbe_link_pkg::cbe_type cmd;
    cbe_link_pkg::word_type addr;
    cbe_link_pkg::word_type data;
    cbe_link_pkg::cbe_type be;
  } xfer_type;
  localparam xfer_type XNONE = '{4'hX, 32'hX, 32'hX, 4'hX};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hs = 1'b0;
  logic ds = 1'b0;
  xfer_type hx = '{4'h0, 32'h0, 32'h0, 4'hF};
  xfer_type dx = '{4'h0, 32'h0, 32'h0, 4'hF};
  logic h_done, h_rxv, d_done, d_tv, clk_buf, h_busy, d_busy;
  realtime t_rise = 0.0;
  realtime lk_per;
  cbe_link_pkg::cbe_type h_rxc, h_rxb, d_tc, d_tb, ac;
  cbe_link_pkg::word_type h_rxa, h_rxd, d_ta, d_td, aa;
  xfer_type wq[$], tq[$], hq[$];
  logic [15:0] bnd [4] = '{16'hA000, 16'hA001, 16'h9FFF, 16'hA000};
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h1E2D;
  int wph = 0;
  cbe_link_if lnk();
  always #4 clk_i = ~clk_i;
  cbe_host_end i_cbe_host_end (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(lnk), .start_i(hs), .cmd_i(hx.cmd), .addr_i(hx.addr),
    .data_i(hx.data), .be_n_i(hx.be), .busy_o(h_busy), .done_o(h_done),
    .rx_valid_o(h_rxv), .rx_cmd_o(h_rxc), .rx_addr_o(h_rxa),
    .rx_data_o(h_rxd), .rx_be_n_o(h_rxb));
  cbe_device_end i_cbe_device_end (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(lnk), .init_start_i(ds), .init_cmd_i(dx.cmd),
    .init_addr_i(dx.addr), .init_data_i(dx.data), .init_be_n_i(dx.be),
    .init_busy_o(d_busy), .init_done_o(d_done), .tgt_valid_o(d_tv),
    .tgt_cmd_o(d_tc), .tgt_addr_o(d_ta), .tgt_data_o(d_td),
    .tgt_be_n_o(d_tb), .host_bus_clock_buffered_out_o(clk_buf));
  cbe_link_asserts i_cbe_link_asserts (
    .host_bus_clock(lnk.host_bus_clock), .bus_reset_n(lnk.bus_reset_n),
    .dev_req(lnk.dev_req), .dev_gnt(lnk.dev_gnt), .d_cbe(lnk.d_cbe),
    .h_cbe_oe(lnk.h_cbe_oe), .d_cbe_oe(lnk.d_cbe_oe),
    .d_ad_oe(lnk.d_ad_oe), .h_frame_oe(lnk.h_frame_oe),
    .d_frame_oe(lnk.d_frame_oe), .frame_n(lnk.frame_n));

  task chk_word(input cbe_link_pkg::word_type got,
                input cbe_link_pkg::word_type exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_cbe(input cbe_link_pkg::cbe_type got,
               input cbe_link_pkg::cbe_type exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // compare one observed word against the oldest expected one
  task automatic take(ref xfer_type q[$], input cbe_link_pkg::cbe_type c,
    input cbe_link_pkg::word_type a, input cbe_link_pkg::word_type d,
    input cbe_link_pkg::cbe_type b);
    xfer_type e;
    e = (q.size() != 0) ? q.pop_front() : XNONE;
    chk_cbe(c, e.cmd);
    chk_word(a, e.addr);
    chk_word(d, e.data);
    chk_cbe(b, e.be);
  endtask

  always @(negedge clk_i) begin
    if (d_tv === 1'b1)
      take(tq, d_tc, d_ta, d_td, d_tb);
    if (h_rxv === 1'b1)
      take(hq, h_rxc, h_rxa, h_rxd, h_rxb);
  end

  // wire view: address cycle then one data cycle per frame
  always @(posedge lnk.host_bus_clock) begin
    if (wph == 1) begin
      take(wq, ac, aa, lnk.ad_bus, lnk.cmd_byte_enable_bus);
      wph = 0;
    end else if (lnk.frame_n === 1'b0 && lnk.bus_reset_n === 1'b1) begin
      ac = lnk.cmd_byte_enable_bus;
      aa = lnk.ad_bus;
      wph = 1;
    end
  end

  always @(lnk.host_bus_clock) begin
    if (reset_n_i === 1'b1) begin
      #1;
      chk_cbe({3'h0, clk_buf}, {3'h0, lnk.host_bus_clock});
    end
  end

  // link clock period must lie within the bus clock range
  always @(posedge lnk.host_bus_clock) begin
    lk_per = $realtime - t_rise;
    if (t_rise > 0.0)
      chk_cbe({3'h0, lk_per >= 15.1 && lk_per <= 40.0}, 4'h1);
    t_rise = $realtime;
  end

  task automatic run(input bit dev, input xfer_type x);
    int n;
    @(negedge clk_i);
    wq.push_back(x);
    if (dev) begin
      dx = x;
      ds = 1'b1;
      hq.push_back(x);
    end else begin
      hx = x;
      hs = 1'b1;
      if (x.cmd == 4'h7 && x.addr[31:16] == 16'hA000)
        tq.push_back(x);
    end
    @(negedge clk_i);
    ds = 1'b0;
    hs = 1'b0;
    chk_cbe({3'h0, dev ? d_busy : h_busy}, 4'h1);
    for (n = 0; n < 400; n++) begin
      if ((dev ? d_done : h_done) === 1'b1)
        break;
      @(negedge clk_i);
    end
    chk_cbe({3'h0, n < 400}, 4'h1);
    chk_cbe({3'h0, dev ? d_busy : h_busy}, 4'h0);
    repeat (16) @(negedge clk_i);
  endtask

  initial begin
    #400000;
    failures++;
    stop_test();
  end

  initial begin
    logic [31:0] r;
    xfer_type x;
    int i;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    // every command both ways; last four probe the target window edges
    for (i = 0; i < 36; i++) begin
      r = $random(seed);
      x.cmd = (i < 32) ? i[3:0] : 4'h7;
      x.addr = {(i >= 32) ? bnd[i-32] : (i[4] ? 16'hA000 : r[31:16]),
                r[15:2], 2'h0};
      x.data = $random(seed);
      x.be = r[3:0];
      run(1'b0, x);
      x.addr = {4'h1, r[27:2], 2'h0};
      run(1'b1, x);
    end
    chk_word(cbe_link_pkg::word_type'(wq.size() + tq.size() + hq.size()),
             32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
